// ===== inc/pmds_params.svh
// offsets, field positions, reset values and timing counts of the data bus stretch block
`ifndef PMDS_PARAMS_SVH
`define PMDS_PARAMS_SVH

// register indices; byte address is four times the index
`define PMDS_IDX_CLOCK_CONTROL 10'h08E
`define PMDS_IDX_PAGE_CONTROL 10'h08F
`define PMDS_IDX_STATUS 10'h090

// clock_control_reg fields
`define PMDS_STRETCH_LSB 0
`define PMDS_CDIV_LSB 3
`define PMDS_MULT_BIT 5
// page control fields
`define PMDS_PGEN_BIT 0
`define PMDS_PSEL_LSB 1
// status fields
`define PMDS_BUSY_BIT 0
`define PMDS_SCNT_LSB 1

// reset values
`define PMDS_STRETCH_RST 3'h1
`define PMDS_CDIV_RST 2'h2
`define PMDS_MULT_RST 1'h0
`define PMDS_PGEN_RST 1'h0
`define PMDS_PSEL_RST 2'h0

// fast clocks per system clock for each clock setting
`define PMDS_DIV_4X 13'h0001
`define PMDS_DIV_2X 13'h0002
`define PMDS_DIV_1 13'h0004
`define PMDS_DIV_1024 4096

// timing in system clocks
`define PMDS_STRETCH_SYSCLKS 6'h04
`define PMDS_SETUP_BASE 6'h01
`define PMDS_HOLD_BASE 6'h01
`define PMDS_STROBE_BASE_SHORT 6'h01
`define PMDS_STROBE_BASE_LONG 6'h02
`define PMDS_STRETCH1_STROBE_ADD 6'h02

`endif

// ===== inc/pmds_pkg.sv
// types shared by the data bus stretch block
package pmds_pkg;

  // bus sequencer states
  typedef enum logic [2:0] {
    pmds_idle,
    pmds_start,
    pmds_setup,
    pmds_strobe,
    pmds_hold,
    pmds_finish
  } pmds_state_t;

  // external bus structure
  typedef enum logic [1:0] {
    pmds_nonpage,
    pmds_page1_short,
    pmds_page1_four,
    pmds_page2
  } pmds_mode_t;

endpackage : pmds_pkg

// ===== src/pmds_sys_tick.sv
// system clock enable generator from the clock divide and multiplier settings
`timescale 1ns/100ps
`include "pmds_params.svh"
module pmds_sys_tick #(
  parameter int DIV_SLOW = `PMDS_DIV_1024
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic [1:0] clock_divide_select,
  input wire logic clock_multiplier_select,
  output logic sys_tick
);
  import pmds_pkg::*;

  logic [12:0] div_count; // fast clocks left in this system clock
  logic [12:0] div_load; // reload value for the current setting

  // fast clocks per system clock, less one
  always_comb begin
    case (clock_divide_select)
      2'h0: begin
        div_load = clock_multiplier_select ? `PMDS_DIV_4X : `PMDS_DIV_2X;
      end
      2'h3: begin
        div_load = 13'(DIV_SLOW);
      end
      default: begin
        div_load = `PMDS_DIV_1;
      end
    endcase
    div_load = div_load - 13'h0001;
  end

  // count down and pulse once per system clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count <= 13'h0000;
    end else if (clock_en) begin
      div_count <= (div_count == 13'h0000) ? div_load : div_count - 13'h0001;
    end
  end

  assign sys_tick = (div_count == 13'h0000);

endmodule : pmds_sys_tick

// ===== src/pmds_timing.sv
// lookup of setup, strobe and hold lengths for a stretch setting
`timescale 1ns/100ps
`include "pmds_params.svh"
module pmds_timing (
  input wire logic [2:0] stretch_select,
  input wire pmds_pkg::pmds_mode_t bus_mode,
  output logic [5:0] setup_len,
  output logic [5:0] strobe_len,
  output logic [5:0] hold_len,
  output logic [3:0] stretch_cycles
);
  import pmds_pkg::*;

  logic [5:0] extra; // latch strobe and hold widening for slow settings
  logic [5:0] add_strobe; // strobe widening in system clocks

  // inserted stretch machine cycles per setting
  always_comb begin
    case (stretch_select)
      3'h4: stretch_cycles = 4'h7;
      3'h5: stretch_cycles = 4'h8;
      3'h6: stretch_cycles = 4'h9;
      3'h7: stretch_cycles = 4'hA;
      default: stretch_cycles = {1'b0, stretch_select};
    endcase
  end

  // phase lengths in system clocks
  always_comb begin
    extra = stretch_select[2] ? `PMDS_STRETCH_SYSCLKS : 6'h00;
    if (stretch_select == 3'h0) begin
      add_strobe = 6'h00;
    end else if (stretch_select == 3'h1) begin
      add_strobe = `PMDS_STRETCH1_STROBE_ADD;
    end else begin
      // each further setting adds one stretch machine cycle to the strobe
      add_strobe = 6'({3'h0, stretch_select} * `PMDS_STRETCH_SYSCLKS) - `PMDS_STRETCH1_STROBE_ADD;
    end
    if (bus_mode == pmds_page1_short) begin
      strobe_len = `PMDS_STROBE_BASE_SHORT + add_strobe;
    end else begin
      strobe_len = `PMDS_STROBE_BASE_LONG + add_strobe;
    end
    setup_len = `PMDS_SETUP_BASE + {5'h00, stretch_select != 3'h0} + extra;
    hold_len = `PMDS_HOLD_BASE + {5'h00, stretch_select != 3'h0} + extra;
  end

endmodule : pmds_timing

// ===== src/pmds_bus_ctrl.sv
// external data bus controller with stretch timing and register slave
`timescale 1ns/100ps
`include "pmds_params.svh"
module pmds_bus_ctrl #(
  parameter int DIV_SLOW = `PMDS_DIV_1024
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // register slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu request port
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_ext,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_done,
  output logic cpu_busy,
  // external bus pins
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic port0_oe,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic port2_oe
);
  import pmds_pkg::*;

  // software settings
  logic [2:0] stretch_select; // stretch setting
  logic [1:0] clock_divide_select; // clock divider setting
  logic clock_multiplier_select; // 4x versus 2x multiplier
  logic page_structure_enable; // page bus structures on
  logic [1:0] page_select; // page mode select

  // register slave
  logic avs_ack; // answer cycle of a bus access
  logic [9:0] avs_index; // register index
  logic [31:0] next_readdata; // read mux

  // sequencer
  pmds_state_t state; // bus sequencer state
  pmds_mode_t bus_mode; // bus structure from the settings
  pmds_mode_t acc_mode; // bus structure frozen for this access
  logic sys_tick; // one system clock elapsed
  logic [5:0] phase_cnt; // system clocks left in this phase
  logic [5:0] setup_len; // setup length for the current setting
  logic [5:0] strobe_len; // strobe length for the current setting
  logic [5:0] hold_len; // hold length for the current setting
  logic [3:0] stretch_cycles; // inserted stretch cycles
  logic [5:0] acc_strobe; // strobe length frozen for this access
  logic [5:0] acc_hold; // hold length frozen for this access
  logic [3:0] last_stretch; // stretch cycles of the last external access
  logic req_we; // latched direction
  logic req_ext; // latched external flag
  logic [15:0] req_addr; // latched address
  logic [7:0] req_wdata; // latched write data
  logic phase_end; // last system clock of a phase

  // pin input synchronisers
  logic [7:0] port0_meta; // first stage
  logic [7:0] port0_sync; // second stage
  logic [7:0] port2_meta; // first stage
  logic [7:0] port2_sync; // second stage

  // system clock enable
  pmds_sys_tick #(
    .DIV_SLOW(DIV_SLOW)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .clock_divide_select(clock_divide_select),
    .clock_multiplier_select(clock_multiplier_select),
    .sys_tick(sys_tick)
  );

  // phase lengths for the live stretch setting
  pmds_timing u_timing (
    .stretch_select(stretch_select),
    .bus_mode(bus_mode),
    .setup_len(setup_len),
    .strobe_len(strobe_len),
    .hold_len(hold_len),
    .stretch_cycles(stretch_cycles)
  );

  // bus structure from enable and select bits
  always_comb begin
    if (!page_structure_enable) begin
      bus_mode = pmds_nonpage;
    end else begin
      case (page_select)
        2'h0: bus_mode = pmds_page1_short;
        2'h1: bus_mode = pmds_page1_short;
        2'h2: bus_mode = pmds_page1_four;
        default: bus_mode = pmds_page2;
      endcase
    end
  end

  // two-flop synchronisers on the data ports
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port0_meta <= 8'h00;
      port0_sync <= 8'h00;
      port2_meta <= 8'h00;
      port2_sync <= 8'h00;
    end else if (clock_en) begin
      port0_meta <= port0_in;
      port0_sync <= port0_meta;
      port2_meta <= port2_in;
      port2_sync <= port2_meta;
    end
  end

  // register slave: one wait cycle, answer on the next
  assign avs_index = avs_address[11:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~avs_ack;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_ack <= 1'b0;
    end else if (clock_en) begin
      avs_ack <= (avs_read | avs_write) & ~avs_ack;
    end
  end

  // settings written by software at any time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stretch_select <= `PMDS_STRETCH_RST;
      clock_divide_select <= `PMDS_CDIV_RST;
      clock_multiplier_select <= `PMDS_MULT_RST;
      page_structure_enable <= `PMDS_PGEN_RST;
      page_select <= `PMDS_PSEL_RST;
    end else if (clock_en && avs_write && avs_ack && avs_byteenable[0]) begin
      if (avs_index == `PMDS_IDX_CLOCK_CONTROL) begin
        // taken even mid access; the running access keeps its frozen phase lengths but follows a new clock divide setting
        stretch_select <= avs_writedata[`PMDS_STRETCH_LSB +: 3];
        clock_divide_select <= avs_writedata[`PMDS_CDIV_LSB +: 2];
        clock_multiplier_select <= avs_writedata[`PMDS_MULT_BIT];
      end else if (avs_index == `PMDS_IDX_PAGE_CONTROL) begin
        page_structure_enable <= avs_writedata[`PMDS_PGEN_BIT];
        page_select <= avs_writedata[`PMDS_PSEL_LSB +: 2];
      end
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_index)
      `PMDS_IDX_CLOCK_CONTROL: begin
        next_readdata[`PMDS_STRETCH_LSB +: 3] = stretch_select;
        next_readdata[`PMDS_CDIV_LSB +: 2] = clock_divide_select;
        next_readdata[`PMDS_MULT_BIT] = clock_multiplier_select;
      end
      `PMDS_IDX_PAGE_CONTROL: begin
        next_readdata[`PMDS_PGEN_BIT] = page_structure_enable;
        next_readdata[`PMDS_PSEL_LSB +: 2] = page_select;
      end
      `PMDS_IDX_STATUS: begin
        next_readdata[`PMDS_BUSY_BIT] = cpu_busy;
        next_readdata[`PMDS_SCNT_LSB +: 4] = last_stretch;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // read data registered in the wait cycle, stands in the answer cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clock_en && avs_read && !avs_ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // cpu request latch, taken only while idle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_we <= 1'b0;
      req_ext <= 1'b0;
      req_addr <= 16'h0000;
      req_wdata <= 8'h00;
    end else if (clock_en && state == pmds_idle && cpu_req) begin
      req_we <= cpu_we;
      req_ext <= cpu_ext;
      req_addr <= cpu_addr;
      req_wdata <= cpu_wdata;
    end
  end

  assign cpu_busy = (state != pmds_idle);
  assign phase_end = sys_tick && (phase_cnt == 6'h01);

  // bus sequencer, stepping on system clocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= pmds_idle;
      phase_cnt <= 6'h00;
      acc_mode <= pmds_nonpage;
      acc_strobe <= 6'h00;
      acc_hold <= 6'h00;
    end else if (clock_en) begin
      case (state)
        pmds_idle: begin
          if (cpu_req) begin
            state <= pmds_start;
          end
        end
        pmds_start: begin
          if (sys_tick) begin
            if (!req_ext) begin
              // internal and code accesses: one unstretched system clock
              state <= pmds_finish;
            end else begin
              // timing frozen at the start of the external access
              state <= pmds_setup;
              phase_cnt <= setup_len;
              acc_strobe <= strobe_len;
              acc_hold <= hold_len;
              acc_mode <= bus_mode;
            end
          end
        end
        pmds_setup: begin
          if (sys_tick) begin
            phase_cnt <= phase_cnt - 6'h01;
          end
          if (phase_end) begin
            state <= pmds_strobe;
            phase_cnt <= acc_strobe;
          end
        end
        pmds_strobe: begin
          if (sys_tick) begin
            phase_cnt <= phase_cnt - 6'h01;
          end
          if (phase_end) begin
            state <= pmds_hold;
            phase_cnt <= acc_hold;
          end
        end
        pmds_hold: begin
          if (sys_tick) begin
            phase_cnt <= phase_cnt - 6'h01;
          end
          if (phase_end) begin
            state <= pmds_finish;
          end
        end
        pmds_finish: begin
          state <= pmds_idle;
        end
        default: begin
          state <= pmds_idle;
        end
      endcase
    end
  end

  // completion pulse and read data capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_done <= 1'b0;
      cpu_rdata <= 8'h00;
      last_stretch <= 4'h0;
    end else if (clock_en) begin
      cpu_done <= (state == pmds_finish);
      if (state == pmds_strobe && phase_end && !req_we) begin
        // data bus position depends on the bus structure
        cpu_rdata <= (acc_mode == pmds_page2) ? port2_sync : port0_sync;
      end
      if (state == pmds_start && sys_tick && req_ext) begin
        last_stretch <= stretch_cycles;
      end
    end
  end

  // pins: latch strobe in setup, read or write strobe in the strobe phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else if (clock_en) begin
      ale <= (state == pmds_setup) && !phase_end;
      rd_n <= !((state == pmds_setup && phase_end && !req_we) ||
                (state == pmds_strobe && !phase_end && !req_we));
      wr_n <= !((state == pmds_setup && phase_end && req_we) ||
                (state == pmds_strobe && !phase_end && req_we));
    end
  end

  // address and data on the ports per bus structure
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      port2_out <= 8'h00;
      port2_oe <= 1'b0;
    end else if (clock_en) begin
      if (state == pmds_setup && !phase_end) begin
        // address phase
        port0_oe <= 1'b1;
        port2_oe <= 1'b1;
        case (acc_mode)
          pmds_page2: begin
            port0_out <= req_addr[7:0];
            port2_out <= req_addr[15:8];
          end
          pmds_nonpage: begin
            port0_out <= req_addr[7:0];
            port2_out <= req_addr[15:8];
          end
          default: begin
            port0_out <= req_addr[15:8];
            port2_out <= req_addr[7:0];
          end
        endcase
      end else if (state == pmds_setup || state == pmds_strobe || state == pmds_hold) begin
        // data phase: float for reads, drive for writes through hold
        if (acc_mode == pmds_page2) begin
          port2_out <= req_wdata;
          port2_oe <= req_we;
        end else begin
          port0_out <= req_wdata;
          port0_oe <= req_we;
        end
      end else begin
        port0_oe <= 1'b0;
        port2_oe <= 1'b0;
      end
    end
  end

endmodule : pmds_bus_ctrl

// ===== testbench/pmds_checker.sv
// assertion checker for the data bus stretch controller
`timescale 1ns/100ps
`include "pmds_params.svh"
module pmds_checker #(
  parameter int DIV_SLOW = `PMDS_DIV_1024
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic cpu_req,
  input wire logic cpu_ext,
  input wire logic cpu_busy,
  input wire logic cpu_done,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port0_oe,
  input wire logic port2_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] cc; // shadow of clock control
  logic [2:0] pc; // shadow of page control
  logic [19:0] low_cnt; // clocks the strobe has been low, room for the slowest setting
  int exp_low;
  wire take = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire p2d = pc[0] && pc[2:1] == 2'h3; // data port is port 2
  // follow register writes to know the expected timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cc <= 8'h11;
      pc <= 3'h0;
    end else if (take && avs_address[11:2] == `PMDS_IDX_CLOCK_CONTROL) begin
      cc <= avs_writedata[7:0];
    end else if (take && avs_address[11:2] == `PMDS_IDX_PAGE_CONTROL) begin
      pc <= avs_writedata[2:0];
    end
  end
  // strobe width in fast clocks for the current settings
  always_comb begin
    int dv;
    dv = (cc[5] && cc[4:3] == 2'h0) ? 1 : (cc[4:3] == 2'h0) ? 2 : (cc[4:3] == 2'h3) ? DIV_SLOW : 4;
    exp_low = ((pc[0] && !pc[2]) ? 1 : 2) + ((cc[2:0] == 3'h0) ? 0 : 4 * int'(cc[2:0]) - 2);
    exp_low = exp_low * dv;
  end
  // count strobe low time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt <= 20'h00000;
    end else if (!rd_n || !wr_n) begin
      low_cnt <= low_cnt + 20'h00001;
    end else begin
      low_cnt <= 20'h00000;
    end
  end
  a_strobe_width: assert property ($rose(rd_n && wr_n) |-> int'(low_cnt) == exp_low)
    else $error("strobe width wrong");
  a_strobes_apart: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
  a_read_floats: assert property (!rd_n |-> !(p2d ? port2_oe : port0_oe))
    else $error("data port driven during read");
  a_write_drives: assert property (!wr_n |-> (p2d ? port2_oe : port0_oe))
    else $error("data port not driven during write");
  a_ale_apart: assert property (ale |-> rd_n && wr_n)
    else $error("latch strobe overlaps data strobe");
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register access wait not one cycle");
  a_done_pulse: assert property (cpu_done |=> !cpu_done)
    else $error("done longer than one clock");
  a_internal_quiet: assert property (cpu_req && !cpu_busy && !cpu_ext |=> (rd_n && wr_n && !ale)[*8])
    else $error("internal access moved external pins");
  a_busy_taken: assert property (clock_en && cpu_req && !cpu_busy |=> cpu_busy)
    else $error("request not taken");
endmodule : pmds_checker
bind pmds_bus_ctrl pmds_checker #(.DIV_SLOW(DIV_SLOW)) chk_i (.clock, .rst, .clock_en, .avs_address, .avs_read,
  .avs_write,
  .avs_byteenable, .avs_writedata, .avs_waitrequest, .cpu_req, .cpu_ext, .cpu_busy, .cpu_done, .ale, .rd_n, .wr_n,
  .port0_oe, .port2_oe);

// ===== testbench/pmds_sram_model.sv
// behavioural external data memory on the multiplexed ports
`timescale 1ns/100ps
module pmds_sram_model #(
  parameter int SLOW = 1
) (
  input wire logic clock,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic page1,
  input wire logic data_p2,
  input wire logic [7:0] port0,
  input wire logic [7:0] port2,
  output logic [7:0] drv0,
  output logic [7:0] drv2
);
  logic [7:0] mem [256];
  logic [7:0] addr; // latched low address byte
  logic [7:0] tog; // pattern on a released line
  int rd_age;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    tog = 8'h00;
    addr = 8'h00;
    rd_age = 0;
  end
  // latch address, store writes, age the read
  always @(posedge clock) begin
    if (ale) begin
      addr <= page1 ? port2 : port0;
    end
    if (!wr_n) begin
      mem[addr] <= data_p2 ? port2 : port0;
    end
    rd_age <= rd_n ? 0 : rd_age + 1;
    tog <= ~tog;
  end
  // data only after the access time
  wire give = !rd_n && rd_age >= SLOW;
  assign drv0 = (give && !data_p2) ? mem[addr] : tog;
  assign drv2 = (give && data_p2) ? mem[addr] : tog;
endmodule : pmds_sram_model

// ===== testbench/tb_page_mode_data_bus_stretch.sv
// self-checking bench for the page mode data bus stretch controller
`timescale 1ns/100ps
`include "pmds_params.svh"
module tb_page_mode_data_bus_stretch;
  logic clock, rst, clock_en, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic cpu_req, cpu_we, cpu_ext, cpu_done, cpu_busy, ale, rd_n, wr_n, port0_oe, port2_oe, page1, data_p2;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, port0_out, port2_out, drv0, drv2;
  int err_total, n_compared, cyc;
  int cyc_map [8] = '{0, 1, 2, 3, 7, 8, 9, 10};
  logic [7:0] cfg [4] = '{8'h21, 8'h01, 8'h11, 8'h19};
  int dvs [4] = '{1, 2, 4, 8};
  wire [7:0] p0 = port0_oe ? port0_out : drv0;
  wire [7:0] p2 = port2_oe ? port2_out : drv2;
  pmds_bus_ctrl #(.DIV_SLOW(8)) uut (.clock, .rst, .clock_en, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_req, .cpu_we, .cpu_ext, .cpu_addr, .cpu_wdata, .cpu_rdata,
    .cpu_done, .cpu_busy, .ale, .rd_n, .wr_n, .port0_in(p0), .port0_out, .port0_oe, .port2_in(p2), .port2_out,
    .port2_oe);
  pmds_sram_model #(.SLOW(1)) mem_model (.clock, .ale, .rd_n, .wr_n, .page1, .data_p2, .port0(p0), .port2(p2),
    .drv0, .drv2);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one register access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic [3:0] be,
    output logic [31:0] q);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    // hold everything until the rising edge that samples waitrequest low
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // one cpu access; counts strobe low clocks until done
  task automatic acc(input logic we, input logic ext, input logic [15:0] a, input logic [7:0] d, output int w,
    output logic [7:0] q);
    int n;
    w = 0;
    n = 0;
    @(posedge clock);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_ext <= ext;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clock);
    cpu_req <= 1'b0;
    do begin
      @(negedge clock);
      if (!rd_n || !wr_n) w++;
      n++;
    end while (cpu_done !== 1'b1 && n < 5000);
    q = cpu_rdata;
    chk(cpu_done, 1, "access done");
  endtask : acc
  function automatic int ew(int s, int base, int dv);
    return (base + (s == 0 ? 0 : 4 * s - 2)) * dv;
  endfunction : ew
  task automatic t_regs;
    logic [31:0] q;
    bus(0, `PMDS_IDX_CLOCK_CONTROL, 0, 4'hF, q);
    chk(q[7:0], 8'h11, "clock control reset");
    bus(0, `PMDS_IDX_PAGE_CONTROL, 0, 4'hF, q);
    chk(q[2:0], 3'h0, "page control reset");
    bus(1, `PMDS_IDX_CLOCK_CONTROL, 32'h07, 4'hE, q);
    bus(0, `PMDS_IDX_CLOCK_CONTROL, 0, 4'hF, q);
    chk(q[7:0], 8'h11, "lane off write");
    bus(1, 10'h0A0, 32'hFF, 4'hF, q);
    bus(0, 10'h0A0, 0, 4'hF, q);
    chk(q, 32'h0, "unmapped read");
    bus(1, `PMDS_IDX_STATUS, 32'hFF, 4'hF, q);
    bus(0, `PMDS_IDX_STATUS, 0, 4'hF, q);
    chk(q[0], 1'b0, "status read only");
    bus(1, `PMDS_IDX_CLOCK_CONTROL, 32'h13, 4'hF, q);
    bus(0, `PMDS_IDX_CLOCK_CONTROL, 0, 4'hF, q);
    chk(q[5:0], 6'h13, "clock control write");
    $display("test regs done");
  endtask : t_regs
  task automatic t_stretch;
    logic [31:0] q;
    logic [7:0] d;
    int w;
    for (int s = 7; s >= 0; s--) begin
      bus(1, `PMDS_IDX_CLOCK_CONTROL, 32'h10 | s, 4'hF, q);
      acc(0, 1, 16'h0433, 0, w, d);
      chk(w, ew(s, 2, 4), "read strobe width");
      chk(d, 8'h33 ^ 8'h5A, "read data");
      bus(0, `PMDS_IDX_STATUS, 0, 4'hF, q);
      chk(q[4:1], cyc_map[s], "stretch cycles");
    end
    $display("test stretch done");
  endtask : t_stretch
  task automatic t_modes;
    logic [31:0] q;
    logic [7:0] d;
    int w;
    bus(1, `PMDS_IDX_CLOCK_CONTROL, 32'h12, 4'hF, q);
    for (int m = 0; m < 4; m++) begin
      page1 <= (m < 3);
      data_p2 <= (m == 3);
      bus(1, `PMDS_IDX_PAGE_CONTROL, 32'h1 | (m << 1), 4'hF, q);
      acc(1, 1, 16'(16'h0440 + m), 8'(8'hA0 + m), w, d);
      chk(w, ew(2, (m < 2) ? 1 : 2, 4), "write strobe width");
      acc(0, 1, 16'(16'h0440 + m), 0, w, d);
      chk(d, 8'hA0 + m, "page read back");
    end
    bus(1, `PMDS_IDX_PAGE_CONTROL, 0, 4'hF, q);
    page1 <= 1'b0;
    data_p2 <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_clock;
    logic [31:0] q;
    logic [7:0] d;
    int w;
    for (int k = 0; k < 4; k++) begin
      bus(1, `PMDS_IDX_CLOCK_CONTROL, {24'h0, cfg[k]}, 4'hF, q);
      acc(0, 1, 16'h0433, 0, w, d);
      chk(w, ew(1, 2, dvs[k]), "strobe width per clock setting");
    end
    bus(1, `PMDS_IDX_CLOCK_CONTROL, 32'h11, 4'hF, q);
    $display("test clock done");
  endtask : t_clock
  task automatic t_internal;
    logic [7:0] d;
    int w;
    acc(0, 0, 16'h0010, 0, w, d);
    chk(w, 0, "internal access strobe");
    repeat (10) @(posedge clock);
    // with the clock enable low a pending request must not be taken
    clock_en <= 1'b0;
    cpu_req <= 1'b1;
    repeat (4) @(negedge clock);
    chk(cpu_busy, 0, "request frozen while enable low");
    @(posedge clock);
    cpu_req <= 1'b0;
    clock_en <= 1'b1;
    repeat (4) @(posedge clock);
    $display("test internal done");
  endtask : t_internal
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    clock_en = 1'b1;
    {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
    {cpu_req, cpu_we, cpu_ext, cpu_addr, cpu_wdata, page1, data_p2} = '0;
    {err_total, n_compared, cyc} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_stretch();
    t_modes();
    t_clock();
    t_internal();
    give_verdict();
  end
endmodule : tb_page_mode_data_bus_stretch
